// *** verilog/drs_pkg.sv ***
// Package for the descriptor ring status block
package drs_pkg;

	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] DRS_OFS_CTRL     = 8'h00;
	localparam logic [7:0] DRS_OFS_RX_BASE  = 8'h04;
	localparam logic [7:0] DRS_OFS_TX_BASE  = 8'h08;
	localparam logic [7:0] DRS_OFS_STATUS   = 8'h0C;
	localparam logic [7:0] DRS_OFS_RX_PTR   = 8'h10;
	localparam logic [7:0] DRS_OFS_TX_PTR   = 8'h14;

	// ==========================================
	// Field positions
	localparam int DRS_OWN_BIT       = 31;
	localparam int DRS_ES_BIT        = 15;
	localparam int DRS_TRUNC_BIT     = 14;
	localparam int DRS_CSUM_EN_BIT   = 27;
	localparam int DRS_WDOG_STAT_BIT = 9;
	localparam int DRS_CHAIN_BIT     = 24;
	localparam int DRS_FL_LSB        = 16;

	// ==========================================
	// Reset values and frame limits
	localparam logic [31:0] DRS_RST_WORD  = 32'h0000_0000;
	localparam logic [13:0] DRS_MIN_FRAME = 14'h0040;
	localparam logic [13:0] DRS_MAX_FRAME = 14'h05EE;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic        paddr_ok;
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} drs_apb_req_t;

	typedef struct packed {
		logic        trunc;
		logic        overflow;
		logic        late_coll;
		logic        crc_err;
		logic        align_err;
		logic        multicast;
		logic        eth_type;
		logic        watchdog;
		logic        phy_err;
		logic        addr_miss;
		logic [1:0]  loop_src;
		logic        ip_fail;
		logic        l4_fail;
		logic        is_ip;
		logic        is_tcp;
		logic        is_udp;
	} drs_rx_info_t;

	typedef struct packed {
		logic jabber;
		logic carrier_loss;
		logic no_carrier;
		logic late_coll;
		logic excess_coll;
		logic underrun;
	} drs_tx_info_t;

	typedef enum logic [3:0] {
		DRS_IDLE = 4'b0001,
		DRS_RX   = 4'b0010,
		DRS_TX   = 4'b0100,
		DRS_WB   = 4'b1000
	} drs_state_t;

	typedef struct packed {
		drs_state_t  st;
		logic        csum_en;
		logic        rx_run;
		logic        tx_run;
		logic        wdog_stat;
		logic [31:0] rx_base;
		logic [31:0] tx_base;
		logic [31:0] rx_ptr;
		logic [31:0] tx_ptr;
		logic        rx_first;
		logic [13:0] rx_total;
		logic [31:0] prdata;
		logic        mem_req;
		logic        mem_wr;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
		logic        rx_done;
		logic        tx_done;
		logic [31:0] next_ptr;
	} drs_state_s_t;

endpackage

// *** verilog/drs_descriptor_ring_status.sv ***
// Descriptor walker and status writer for the receive and transmit chains
// Notes on behaviour
// - Device clears rx owner after placing packet; driver sets it after removing data.
// - rx_byte_count in rx word0 holds the packet's total byte count.
// - Rx status written after buffer fills; meaningful only with last_segment_mark.
// - error_summary_bit set if truncation, short, oversize, late collision, CRC, overflow.
// - buffer_shortage_truncation set when frame cut short for lack of buffer.
// - Checksum mode: bit13 IP checksum fail, bit12 TCP/UDP checksum fail.
// - Otherwise bits13..12 give source: normal, internal, PHY digital, PHY analog loop.
// - short_frame_bit for frames under 64 bytes, valid at last segment without overflow.
// - group_address_bit set for multicast destination.
// - first_segment_mark on frame start descriptor, last_segment_mark on end descriptor.
// - oversize_frame_bit when frame exceeds 1518 bytes.
// - rx_late_collision_bit when late collision seen during reception.
// - Bit5 is IP flag in checksum mode, else Ethernet-type frame flag.
// - Bit4 is TCP flag, else watchdog timeout also setting status bit 9.
// - Bit3 is UDP flag, else physical layer error.
// - alignment_fault_bit on non-byte end; crc_fault_bit on CRC mismatch.
// - rx_overflow_bit on receive FIFO overflow, meaningful at last segment.
// - Driver sets tx owner when ready; device clears it after sending buffer.
// - Tx error summary set on jabber, carrier loss, no carrier, collisions, underrun.
// - Tx error summary sits in bit 15 of tx word0.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps

module drs_descriptor_ring_status
	import drs_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic              pready,
	output logic              pslverr,
	output logic [31:0]       prdata,
	output logic              mem_req,
	output logic              mem_wr,
	output logic [31:0]       mem_addr,
	output logic [31:0]       mem_wdata,
	input  wire logic         mem_ack,
	input  wire logic [31:0]  mem_rdata,
	input  wire logic         rx_seg_valid,
	input  wire logic         rx_seg_last,
	input  wire logic [10:0]  rx_seg_bytes,
	input  wire drs_rx_info_t rx_info,
	output logic              rx_seg_ready,
	input  wire logic         tx_seg_valid,
	input  wire drs_tx_info_t tx_info,
	output logic              tx_seg_ready,
	output logic              rx_no_desc,
	output logic              tx_no_desc
);

	drs_state_s_t s_r;
	drs_state_s_t s_nxt;

	// ==========================================
	// Helpers
	function automatic logic [31:0] drs_rx_status(
		input drs_rx_info_t i,
		input logic         first,
		input logic         last,
		input logic [13:0]  total,
		input logic         csum
	);
		logic [31:0] w;
		logic        short_f;
		logic        long_f;
		w = DRS_RST_WORD;
		short_f = last && !i.overflow && (total < DRS_MIN_FRAME);
		long_f  = last && (total > DRS_MAX_FRAME);
		w[30] = i.addr_miss;
		w[29:DRS_FL_LSB] = total;
		w[9] = first;
		w[8] = last;
		// error bits only at last segment
		if (last)
		begin
			w[DRS_TRUNC_BIT] = i.trunc;
			w[11] = short_f;
			w[10] = i.multicast;
			w[7] = long_f;
			w[6] = i.late_coll;
			w[2] = i.align_err;
			w[1] = i.crc_err;
			w[0] = i.overflow;
			if (csum)
			begin
				w[13] = i.ip_fail;
				w[12] = i.l4_fail;
				w[5] = i.is_ip;
				w[4] = i.is_tcp;
				w[3] = i.is_udp;
			end
			else
			begin
				w[13:12] = i.loop_src;
				w[5] = i.eth_type;
				w[4] = i.watchdog;
				w[3] = i.phy_err;
			end
			w[DRS_ES_BIT] = i.trunc | short_f | long_f | i.late_coll | i.crc_err | i.overflow;
		end
		return w;
	endfunction

	function automatic logic [31:0] drs_tx_status(input drs_tx_info_t i);
		logic [31:0] w;
		w = DRS_RST_WORD;
		w[14] = i.jabber;
		w[12] = i.underrun;
		w[11] = i.carrier_loss;
		w[10] = i.no_carrier;
		w[9]  = i.late_coll;
		w[8]  = i.excess_coll;
		w[1]  = i.underrun;
		w[DRS_ES_BIT] = i.jabber | i.carrier_loss | i.no_carrier | i.late_coll
			| i.excess_coll | i.underrun;
		return w;
	endfunction

	// ==========================================
	// Next state
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rx_done = 1'b0;
		s_nxt.tx_done = 1'b0;
		pready  = 1'b1;
		pslverr = 1'b0;
		rx_seg_ready = 1'b0;
		tx_seg_ready = 1'b0;

		// APB setup phase reads are latched; writes at access
		if (psel && !penable)
		begin
			if (paddr == DRS_OFS_CTRL)
				s_nxt.prdata = {4'h0, s_r.csum_en, 17'h0, s_r.wdog_stat, 7'h0,
					s_r.tx_run, s_r.rx_run};
			else if (paddr == DRS_OFS_RX_BASE)
				s_nxt.prdata = s_r.rx_base;
			else if (paddr == DRS_OFS_TX_BASE)
				s_nxt.prdata = s_r.tx_base;
			else if (paddr == DRS_OFS_STATUS)
				s_nxt.prdata = {28'h0, s_r.st};
			else if (paddr == DRS_OFS_RX_PTR)
				s_nxt.prdata = s_r.rx_ptr;
			else if (paddr == DRS_OFS_TX_PTR)
				s_nxt.prdata = s_r.tx_ptr;
			else
				s_nxt.prdata = DRS_RST_WORD;
		end
		if (psel && penable)
		begin
			if (paddr > DRS_OFS_TX_PTR || paddr[1:0] != 2'b00)
				pslverr = 1'b1;
			else if (pwrite)
			begin
				if (paddr == DRS_OFS_CTRL)
				begin
					s_nxt.csum_en = pwdata[DRS_CSUM_EN_BIT];
					s_nxt.rx_run  = pwdata[0];
					s_nxt.tx_run  = pwdata[1];
					if (pwdata[DRS_WDOG_STAT_BIT])
						s_nxt.wdog_stat = 1'b0;
				end
				else if (paddr == DRS_OFS_RX_BASE)
				begin
					s_nxt.rx_base = pwdata;
					s_nxt.rx_ptr  = pwdata;
				end
				else if (paddr == DRS_OFS_TX_BASE)
				begin
					s_nxt.tx_base = pwdata;
					s_nxt.tx_ptr  = pwdata;
				end
			end
		end

		case (s_r.st)
			DRS_IDLE:
			begin
				s_nxt.mem_req = 1'b0;
				if (s_r.rx_run && rx_seg_valid)
				begin
					// Fetch rx word0 for ownership
					s_nxt.st = DRS_RX;
					s_nxt.mem_req  = 1'b1;
					s_nxt.mem_wr   = 1'b0;
					s_nxt.mem_addr = s_r.rx_ptr;
				end
				else if (s_r.tx_run && tx_seg_valid)
				begin
					s_nxt.st = DRS_TX;
					s_nxt.mem_req  = 1'b1;
					s_nxt.mem_wr   = 1'b0;
					s_nxt.mem_addr = s_r.tx_ptr;
				end
			end
			DRS_RX:
			begin
				if (mem_ack && s_r.mem_addr == s_r.rx_ptr)
				begin
					if (!mem_rdata[DRS_OWN_BIT])
					begin
						s_nxt.mem_req = 1'b0;
						s_nxt.st = DRS_IDLE;
					end
					else
						// Fetch next pointer from word3
						s_nxt.mem_addr = s_r.rx_ptr + 32'h0000_000C;
				end
				else if (mem_ack)
				begin
					s_nxt.next_ptr = mem_rdata;
					s_nxt.mem_wdata = drs_rx_status(rx_info, s_r.rx_first, rx_seg_last,
						s_r.rx_total + {3'h0, rx_seg_bytes}, s_r.csum_en);
					s_nxt.rx_total = rx_seg_last ? 14'h0 : s_r.rx_total + {3'h0, rx_seg_bytes};
					s_nxt.rx_first = rx_seg_last;
					if (rx_seg_last && !s_r.csum_en && rx_info.watchdog)
						s_nxt.wdog_stat = 1'b1;
					s_nxt.rx_done  = 1'b1;
					s_nxt.mem_wr   = 1'b1;
					s_nxt.mem_addr = s_r.rx_ptr;
					s_nxt.st = DRS_WB;
					rx_seg_ready = 1'b1;
				end
			end
			DRS_TX:
			begin
				if (mem_ack && s_r.mem_addr == s_r.tx_ptr)
				begin
					if (!mem_rdata[DRS_OWN_BIT])
					begin
						s_nxt.mem_req = 1'b0;
						s_nxt.st = DRS_IDLE;
					end
					else
						s_nxt.mem_addr = s_r.tx_ptr + 32'h0000_000C;
				end
				else if (mem_ack)
				begin
					s_nxt.next_ptr  = mem_rdata;
					s_nxt.mem_wdata = drs_tx_status(tx_info);
					s_nxt.tx_done   = 1'b1;
					s_nxt.mem_wr    = 1'b1;
					s_nxt.mem_addr  = s_r.tx_ptr;
					s_nxt.st = DRS_WB;
					tx_seg_ready = 1'b1;
				end
			end
			DRS_WB:
			begin
				if (mem_ack)
				begin
					s_nxt.mem_req = 1'b0;
					s_nxt.mem_wr  = 1'b0;
					if (s_r.mem_addr == s_r.rx_ptr && s_r.rx_done == 1'b0 && s_r.rx_run)
						s_nxt.rx_ptr = s_r.next_ptr;
					if (s_r.mem_addr == s_r.rx_ptr)
						s_nxt.rx_ptr = s_r.next_ptr;
					else
						s_nxt.tx_ptr = s_r.next_ptr;
					s_nxt.st = DRS_IDLE;
				end
			end
			default:
				s_nxt.st = DRS_IDLE;
		endcase
	end

	// ==========================================
	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r <= '0;
			s_r.st <= DRS_IDLE;
			s_r.rx_first <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// ==========================================
	// Outputs
	assign prdata    = s_r.prdata;
	assign mem_req   = s_r.mem_req;
	assign mem_wr    = s_r.mem_wr;
	assign mem_addr  = s_r.mem_addr;
	assign mem_wdata = s_r.mem_wdata;
	assign rx_no_desc = (s_r.st == DRS_RX) && mem_ack && (s_r.mem_addr == s_r.rx_ptr)
		&& !mem_rdata[DRS_OWN_BIT];
	assign tx_no_desc = (s_r.st == DRS_TX) && mem_ack && (s_r.mem_addr == s_r.tx_ptr)
		&& !mem_rdata[DRS_OWN_BIT];

endmodule

// *** bench/drs_assertions.sv ***
// Port checker for descriptor write-back and memory handshake
`timescale 1ns/1ps
module drs_checker
	import drs_pkg::*;
(
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic         mem_req,
	input wire logic         mem_wr,
	input wire logic [31:0]  mem_addr,
	input wire logic [31:0]  mem_wdata,
	input wire logic         mem_ack,
	input wire logic         rx_seg_valid,
	input wire logic         rx_seg_last,
	input wire drs_rx_info_t rx_info,
	input wire logic         tx_seg_valid,
	input wire drs_tx_info_t tx_info,
	input wire logic         rx_seg_ready,
	input wire logic         tx_seg_ready
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic         rxw;
	logic         txw;
	logic         rx_sel;
	logic         rx_last_q;
	drs_rx_info_t rx_info_q;
	drs_tx_info_t tx_info_q;
	// Segment status captured when taken, held for the write-back
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_sel    <= 1'b0;
			rx_last_q <= 1'b0;
			rx_info_q <= '0;
			tx_info_q <= '0;
		end
		else if (rx_seg_ready)
		begin
			rx_sel    <= 1'b1;
			rx_last_q <= rx_seg_last;
			rx_info_q <= rx_info;
		end
		else if (tx_seg_ready)
		begin
			rx_sel    <= 1'b0;
			tx_info_q <= tx_info;
		end
	end
	assign rxw = rx_sel && mem_req && mem_wr;
	assign txw = !rx_sel && mem_req && mem_wr;
	sequence s_wait;
		mem_req && !mem_ack;
	endsequence
	property p_hold;
		s_wait |=> mem_req && $stable(mem_addr) && $stable(mem_wr);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_rx_own;
		rxw |-> !mem_wdata[31];
	endproperty
	a_rx_own: assert property (p_rx_own) else $error("rx owner kept");
	property p_tx_own;
		txw |-> !mem_wdata[31];
	endproperty
	a_tx_own: assert property (p_tx_own) else $error("tx owner kept");
	property p_rx_es;
		rxw && mem_wdata[8] |->
			mem_wdata[15] == |{mem_wdata[14], mem_wdata[11], mem_wdata[7:6], mem_wdata[1:0]};
	endproperty
	a_rx_es: assert property (p_rx_es) else $error("rx summary");
	property p_rx_last;
		rxw |-> mem_wdata[8] == rx_last_q;
	endproperty
	a_rx_last: assert property (p_rx_last) else $error("rx last mark");
	property p_rx_mark;
		rxw && rx_last_q |-> {mem_wdata[14], mem_wdata[10]} ==
			{rx_info_q.trunc, rx_info_q.multicast};
	endproperty
	a_rx_mark: assert property (p_rx_mark) else $error("rx trunc or group");
	property p_rx_fault;
		rxw && rx_last_q |-> {mem_wdata[6], mem_wdata[2:0]} ==
			{rx_info_q.late_coll, rx_info_q.align_err, rx_info_q.crc_err, rx_info_q.overflow};
	endproperty
	a_rx_fault: assert property (p_rx_fault) else $error("rx faults");
	property p_tx_es;
		txw |-> mem_wdata[15] == |tx_info_q && mem_wdata[14] == tx_info_q.jabber;
	endproperty
	a_tx_es: assert property (p_tx_es) else $error("tx summary");
endmodule

bind drs_descriptor_ring_status drs_checker u_chk (.pclk, .presetn, .mem_req, .mem_wr,
	.mem_addr, .mem_wdata, .mem_ack, .rx_seg_valid, .rx_seg_last, .rx_info, .tx_seg_valid,
	.tx_info, .rx_seg_ready, .tx_seg_ready);

// *** bench/drs_host_mem.sv ***
// Host memory model answering descriptor fetches and write-backs
`timescale 1ns/1ps
module drs_host_mem
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        mem_req,
	input  wire logic        mem_wr,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	input  wire logic [3:0]  lat,
	output logic             mem_ack,
	output logic [31:0]      mem_rdata
);
	logic [31:0] mem [0:255];
	logic [3:0]  cnt;
	// Data toggles when not answering
	always @(posedge pclk or negedge presetn)
	begin
		mem_ack <= 1'b0;
		cnt <= 4'h0;
		mem_rdata <= presetn ? ~mem_rdata : 32'hA5A5_A5A5;
		if (presetn && mem_req && !mem_ack)
		begin
			cnt <= cnt + 4'h1;
			if (cnt >= lat)
			begin
				mem_ack <= 1'b1;
				mem_rdata <= mem[mem_addr[9:2]];
				if (mem_wr)
					mem[mem_addr[9:2]] <= mem_wdata;
			end
		end
	end
endmodule

// *** bench/tb_descriptor_ring_status.sv ***
// Bench driving registers, receive and transmit segments
`timescale 1ns/1ps
module tb_descriptor_ring_status
	import drs_pkg::*;
;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fst, cs;
	logic         mem_req, mem_wr, mem_ack, rx_seg_valid, rx_seg_last, rx_seg_ready;
	logic         tx_seg_valid, tx_seg_ready, rx_no_desc, tx_no_desc;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
	logic [10:0]  rx_seg_bytes;
	logic [9:0]   rx_at, tx_at;
	logic [13:0]  tot;
	logic [3:0]   lat;
	drs_rx_info_t rx_info, ri;
	drs_tx_info_t tx_info;
	int           fail_count, num_checks, k;

	drs_descriptor_ring_status u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .pslverr, .prdata, .mem_req, .mem_wr, .mem_addr, .mem_wdata,
		.mem_ack, .mem_rdata, .rx_seg_valid, .rx_seg_last, .rx_seg_bytes, .rx_info,
		.rx_seg_ready, .tx_seg_valid, .tx_info, .tx_seg_ready, .rx_no_desc, .tx_no_desc);
	drs_host_mem u_mem (.pclk, .presetn, .mem_req, .mem_wr, .mem_addr, .mem_wdata, .lat,
		.mem_ack, .mem_rdata);

	always #2.5 pclk = ~pclk;

	// ==========================================
	// Tasks
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task tmo(input int n);
		if (n >= 200)
		begin
			fail_count++;
			$display("[ERR] wait expected done seen timeout");
			end_of_test();
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 200 && pready !== 1'b1; n++)
			@(posedge pclk);
		tmo(n);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rx_seg(input logic [10:0] b, input logic l, input drs_rx_info_t i, input logic late);
		int n;
		logic nd;
		logic [31:0] e;
		nd = 1'b0;
		u_mem.mem[rx_at[9:2]] = {~late, 31'h0};
		@(posedge pclk);
		rx_seg_valid <= 1'b1;
		rx_seg_last <= l;
		rx_seg_bytes <= b;
		rx_info <= i;
		@(negedge pclk);
		for (n = 0; n < 200 && rx_seg_ready !== 1'b1; n++)
		begin
			nd = nd | (rx_no_desc === 1'b1);
			if (nd)
				u_mem.mem[rx_at[9:2]][31] = 1'b1;
			@(negedge pclk);
		end
		tmo(n);
		@(posedge pclk);
		rx_seg_valid <= 1'b0;
		// Wait for the status write-back to finish
		for (n = 0; n < 200 && mem_req !== 1'b0; n++)
			@(posedge pclk);
		tmo(n);
		tot = (fst ? 14'h0 : tot) + 14'(b);
		e = {2'b00, tot, 6'h0, fst, l, 8'h0};
		if (l)
		begin
			e[15:10] = {1'b0, i.trunc, cs ? {i.ip_fail, i.l4_fail} : i.loop_src,
				(tot < DRS_MIN_FRAME && !i.overflow), i.multicast};
			e[7:0] = {(tot > DRS_MAX_FRAME), i.late_coll, cs ? {i.is_ip, i.is_tcp, i.is_udp}
				: {i.eth_type, i.watchdog, i.phy_err}, i.align_err, i.crc_err, i.overflow};
			e[15] = |{e[14], e[11], e[7:6], e[1:0]};
		end
		apb(1'b0, DRS_OFS_RX_PTR, 32'h0);
		chk("rx_no_desc", {31'h0, nd}, {31'h0, late});
		chk("rx_word0", u_mem.mem[rx_at[9:2]], e);
		rx_at = rx_at ^ 10'h020;
		fst = l;
		chk("rx_ptr", rd, {22'h0, rx_at});
	endtask

	task tx_buf(input drs_tx_info_t t, input logic late);
		int n;
		logic nd;
		nd = 1'b0;
		u_mem.mem[tx_at[9:2]] = {~late, 31'h0};
		@(posedge pclk);
		tx_seg_valid <= 1'b1;
		tx_info <= t;
		@(negedge pclk);
		for (n = 0; n < 200 && tx_seg_ready !== 1'b1; n++)
		begin
			nd = nd | (tx_no_desc === 1'b1);
			if (nd)
				u_mem.mem[tx_at[9:2]][31] = 1'b1;
			@(negedge pclk);
		end
		tmo(n);
		@(posedge pclk);
		tx_seg_valid <= 1'b0;
		for (n = 0; n < 200 && mem_req !== 1'b0; n++)
			@(posedge pclk);
		tmo(n);
		apb(1'b0, DRS_OFS_TX_PTR, 32'h0);
		chk("tx_no_desc", {31'h0, nd}, {31'h0, late});
		chk("tx_word0", u_mem.mem[tx_at[9:2]], {16'h0, |t, t.jabber, 1'b0, t.underrun,
			t.carrier_loss, t.no_carrier, t.late_coll, t.excess_coll, 6'h0, t.underrun, 1'b0});
		tx_at = tx_at ^ 10'h020;
		chk("tx_ptr", rd, {22'h0, tx_at});
	endtask

	// ==========================================
	// Sequence
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, rx_seg_valid, rx_seg_last, tx_seg_valid, cs} = '0;
		{paddr, pwdata, rx_seg_bytes, rx_info, tx_info, tot, lat} = '0;
		{fail_count, num_checks} = '0;
		fst = 1'b1;
		rx_at = 10'h100;
		tx_at = 10'h140;
		for (k = 0; k < 4; k++)
		begin
			u_mem.mem[64 + 8 * k] = 32'h0;
			u_mem.mem[65 + 8 * k] = 32'h0100_0600;
			u_mem.mem[66 + 8 * k] = 32'h0000_0800;
			u_mem.mem[67 + 8 * k] = {22'h0, (10'h100 | 10'(k * 32)) ^ 10'h020};
		end
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, DRS_OFS_CTRL, 32'h0);
		chk("ctrl_reset", rd, DRS_RST_WORD);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped_err", {31'h0, err}, 32'h1);
		apb(1'b1, DRS_OFS_RX_BASE, 32'h0000_0100);
		apb(1'b1, DRS_OFS_TX_BASE, 32'h0000_0140);
		apb(1'b1, DRS_OFS_CTRL, 32'h0000_0003);
		apb(1'b0, DRS_OFS_TX_PTR, 32'h0);
		chk("tx_ptr_base", rd, 32'h0000_0140);
		$display("test registers done");
		for (k = 0; k < 4; k++)
		begin
			ri = '0;
			{ri.loop_src, ri.multicast, ri.eth_type, ri.phy_err} = {k[1:0], k[0], k[1], 1'b1};
			rx_seg(11'h064, 1'b1, ri, k[0]);
		end
		ri = '0;
		{ri.late_coll, ri.align_err} = 2'h3;
		rx_seg(11'h320, 1'b0, '0, 1'b0);
		rx_seg(11'h320, 1'b1, ri, 1'b0);
		ri = '0;
		{ri.trunc, ri.crc_err} = 2'h3;
		rx_seg(11'h028, 1'b1, ri, 1'b0);
		ri = '0;
		{ri.overflow, ri.watchdog} = 2'h3;
		lat = 4'h3;
		rx_seg(11'h064, 1'b1, ri, 1'b0);
		apb(1'b0, DRS_OFS_CTRL, 32'h0);
		chk("wdog_status", rd, 32'h0000_0203);
		apb(1'b1, DRS_OFS_CTRL, 32'h0800_0203);
		apb(1'b0, DRS_OFS_CTRL, 32'h0);
		chk("wdog_clear", rd, 32'h0800_0003);
		$display("test receive errors done");
		cs = 1'b1;
		for (k = 0; k < 4; k++)
		begin
			ri = '0;
			{ri.ip_fail, ri.l4_fail, ri.loop_src} = {k[1:0], 2'h2};
			{ri.is_ip, ri.is_tcp, ri.is_udp} = {k[0], k[1], ~k[0]};
			rx_seg(11'h064, 1'b1, ri, 1'b0);
		end
		$display("test checksum done");
		for (k = 0; k < 7; k++)
			tx_buf(drs_tx_info_t'(6'h01 << k), k[0]);
		$display("test transmit done");
		end_of_test();
	end
endmodule
